// file: core/etrh_pkg.sv
// Package of constants and types for the external trigger handshake controller
package etrh_pkg;

	// ****************************************************************
	// Trigger connector line map
	// ****************************************************************
	localparam int ETRH_LINES = 6;               // Connector signal lines 1..6
	localparam logic [1:0] ETRH_OUT_SEL_RST = 2'h0; // Output on line 1 by default
	localparam logic [1:0] ETRH_IN_SEL_RST = 2'h0;  // Input on line 2 by default
	localparam int ETRH_OUT_LINE_A = 0;          // Line 1 (index 0)
	localparam int ETRH_OUT_LINE_B = 2;          // Line 3
	localparam int ETRH_OUT_LINE_C = 4;          // Line 5
	localparam int ETRH_IN_LINE_A = 1;           // Line 2
	localparam int ETRH_IN_LINE_B = 3;           // Line 4
	localparam int ETRH_IN_LINE_C = 5;           // Line 6

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int ETRH_CLK_PERIOD_NS = 40;      // 25 MHz system clock
	localparam int ETRH_PULSE_NS = 10000;        // Default completion pulse width
	localparam int ETRH_PULSE_CYC = (ETRH_PULSE_NS + ETRH_CLK_PERIOD_NS - 1) / ETRH_CLK_PERIOD_NS;
	localparam int ETRH_CNT_W = 16;              // Width of the pulse counter

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [2:0] {
		ETRH_IDLE = 3'b000,   // Continuous free-running mode
		ETRH_WAIT = 3'b001,   // Waiting for an external trigger
		ETRH_MEAS = 3'b010,   // Measurement in progress
		ETRH_STORE = 3'b011,  // Writing the reading to memory
		ETRH_PULSE = 3'b100   // Driving the completion pulse
	} etrh_state_type;

endpackage

// file: core/etrh_mem.sv
// Reading memory: simple dual-port store, separate write and read addresses, registered read data
`timescale 1ns/1ps
module etrh_mem
	import etrh_pkg::*;
#(
	parameter int DATA_W = 24,
	parameter int DEPTH = 1024,
	parameter int ADDR_W = 10
) (
	// Clock
	input wire logic i_sys_clk,
	// Write port
	input wire logic i_wr_en,
	input wire logic [ADDR_W-1:0] i_wr_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	// Read port
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [DATA_W-1:0] o_rd_data
);

	// Storage array, no reset because it holds data only
	logic [DATA_W-1:0] mem [DEPTH];

	// ****************************************************************
	// Write and registered read
	// ****************************************************************
	always_ff @(posedge i_sys_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
		o_rd_data <= mem[i_rd_addr];
	end

endmodule

// file: core/etrh_ctrl.sv
// Trigger handshake controller: mode toggle, trigger detect, reading store, completion pulse
// Operation
// - External mode accepts line and manual key
// - Entering external mode lights indicator and dashes
// - One manual key press gives one reading
// - Mode key toggles back to continuous
// - Default output line one, input line two
// - Output and input lines relocatable to alternates
// - Trigger recognised on input falling edge
// - Input ignored unless external source configured
// - One completion pulse after triggered measurement
// - Measure, store, then pulse, in order
// - Return to waiting until next trigger
// - Step or scan waits with own indicator
// - Bus trigger command also satisfies detection
// - Pulse only after whole device action done
`timescale 1ns/1ps
module etrh_ctrl
	import etrh_pkg::*;
#(
	parameter int DATA_W = 24,
	parameter int DEPTH = 1024,
	parameter int ADDR_W = 10,
	parameter int PULSE_CYC = ETRH_PULSE_CYC
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Front panel keys, one-cycle press strobes
	input wire logic i_external_mode_select_key,
	input wire logic i_manual_trigger_key,
	input wire logic i_scan_start,
	// Remote trigger command strobe
	input wire logic i_bus_trigger,
	// Trigger sequencing configuration
	input wire logic i_ext_source_en,
	input wire logic [1:0] i_out_line_sel,
	input wire logic [1:0] i_in_line_sel,
	// Connector lines
	input wire logic [ETRH_LINES-1:0] i_link_lines,
	output logic [ETRH_LINES-1:0] o_link_lines,
	output logic [ETRH_LINES-1:0] o_link_lines_oe,
	// Measurement engine (device action incl. filter and hold)
	output logic o_meas_start,
	input wire logic i_meas_done,
	input wire logic [DATA_W-1:0] i_meas_data,
	// Indicators
	output logic o_manual_trigger_key_indicator,
	output logic o_wait_dashes,
	output logic o_scan_wait_indicator,
	output logic o_ext_mode,
	// Reading memory readback
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [DATA_W-1:0] o_rd_data,
	output logic [ADDR_W-1:0] o_wr_count
);

	// ****************************************************************
	// Line selection
	// ****************************************************************
	logic [2:0] in_idx;   // Selected input line index
	logic [2:0] out_idx;  // Selected output line index
	always_comb begin
		// Factory map or one of two alternates
		case (i_in_line_sel)
			2'h1: in_idx = 3'(ETRH_IN_LINE_B);
			2'h2: in_idx = 3'(ETRH_IN_LINE_C);
			default: in_idx = 3'(ETRH_IN_LINE_A);
		endcase
		case (i_out_line_sel)
			2'h1: out_idx = 3'(ETRH_OUT_LINE_B);
			2'h2: out_idx = 3'(ETRH_OUT_LINE_C);
			default: out_idx = 3'(ETRH_OUT_LINE_A);
		endcase
	end

	// ****************************************************************
	// Input synchroniser and falling-edge detector
	// ****************************************************************
	logic sync_a;  // First stage, read only by sync_b
	logic sync_b;  // Second stage
	logic sync_c;  // Delayed copy for edge detect
	logic next_sync_a;
	logic next_sync_b;
	logic next_sync_c;
	logic in_fall;

	// Idle level is high so reset to high avoids a false edge
	always_comb begin
		next_sync_a = i_link_lines[in_idx];
		next_sync_b = sync_a;
		next_sync_c = sync_b;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			sync_c <= 1'b1;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
			sync_c <= next_sync_c;
		end
	end

	assign in_fall = sync_c & ~sync_b;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	etrh_state_type state;
	etrh_state_type next_state;
	logic ext_mode;
	logic next_ext_mode;
	logic scan_wait;
	logic next_scan_wait;
	logic [ETRH_CNT_W-1:0] cnt;
	logic [ETRH_CNT_W-1:0] next_cnt;
	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [DATA_W-1:0] rdg;
	logic [DATA_W-1:0] next_rdg;
	logic meas_start;
	logic next_meas_start;
	logic pulse;
	logic next_pulse;
	logic manual_trigger_key_event;
	logic wr_en;

	// Any accepted trigger source; line edges only count when configured
	assign manual_trigger_key_event = (in_fall & i_ext_source_en) | i_manual_trigger_key | i_bus_trigger;

	always_comb begin
		next_state = state;
		next_ext_mode = ext_mode;
		next_scan_wait = scan_wait;
		next_cnt = cnt;
		next_wr_addr = wr_addr;
		next_rdg = rdg;
		next_meas_start = 1'b0;
		next_pulse = 1'b0;
		wr_en = 1'b0;
		case (state)
			// Continuous mode: free-running, no handshake
			ETRH_IDLE: begin
				if (i_external_mode_select_key) begin
					next_ext_mode = 1'b1;
					next_state = ETRH_WAIT;
				end
			end
			// Wait for exactly one trigger event
			ETRH_WAIT: begin
				if (i_external_mode_select_key) begin
					next_ext_mode = 1'b0;
					next_scan_wait = 1'b0;
					next_state = ETRH_IDLE;
				end else if (manual_trigger_key_event) begin
					// A key press yields exactly one start strobe
					next_meas_start = 1'b1;
					next_scan_wait = 1'b0;
					next_state = ETRH_MEAS;
				end else if (i_scan_start) begin
					next_scan_wait = 1'b1;
				end
			end
			// Hold until the whole device action reports done
			ETRH_MEAS: begin
				if (i_meas_done) begin
					next_rdg = i_meas_data;
					next_state = ETRH_STORE;
				end
			end
			// Store reading before pulse goes out
			ETRH_STORE: begin
				wr_en = 1'b1;
				next_wr_addr = wr_addr + 1'b1;
				next_pulse = 1'b1;
				next_cnt = ETRH_CNT_W'(PULSE_CYC - 1);
				next_state = ETRH_PULSE;
			end
			// Completion pulse; triggers here are not measured
			ETRH_PULSE: begin
				if (cnt == '0) begin
					next_state = ETRH_WAIT;
				end else begin
					next_pulse = 1'b1;
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_state = ETRH_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state <= ETRH_IDLE;
			ext_mode <= 1'b0;
			scan_wait <= 1'b0;
			cnt <= '0;
			wr_addr <= '0;
			rdg <= '0;
			meas_start <= 1'b0;
			pulse <= 1'b0;
		end else begin
			state <= next_state;
			ext_mode <= next_ext_mode;
			scan_wait <= next_scan_wait;
			cnt <= next_cnt;
			wr_addr <= next_wr_addr;
			rdg <= next_rdg;
			meas_start <= next_meas_start;
			pulse <= next_pulse;
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	logic [ETRH_LINES-1:0] next_lines;
	logic [ETRH_LINES-1:0] next_oe;
	always_comb begin
		// Active-low completion pulse on the chosen line, others undriven
		next_lines = '1;
		next_oe = '0;
		next_oe[out_idx] = 1'b1;
		next_lines[out_idx] = ~next_pulse;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_link_lines <= '1;
			o_link_lines_oe <= '0;
			o_manual_trigger_key_indicator <= 1'b0;
			o_wait_dashes <= 1'b0;
			o_scan_wait_indicator <= 1'b0;
			o_ext_mode <= 1'b0;
			o_meas_start <= 1'b0;
			o_wr_count <= '0;
		end else begin
			o_link_lines <= next_lines;
			o_link_lines_oe <= next_oe;
			o_manual_trigger_key_indicator <= next_ext_mode;
			o_wait_dashes <= (next_state == ETRH_WAIT) && !next_scan_wait;
			o_scan_wait_indicator <= (next_state == ETRH_WAIT) && next_scan_wait;
			o_ext_mode <= next_ext_mode;
			o_meas_start <= next_meas_start;
			o_wr_count <= next_wr_addr;
		end
	end

	// Reading memory
	etrh_mem #(.DATA_W(DATA_W), .DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_mem (
		.i_sys_clk(i_sys_clk),
		.i_wr_en(wr_en),
		.i_wr_addr(wr_addr),
		.i_wr_data(rdg),
		.i_rd_addr(i_rd_addr),
		.o_rd_data(o_rd_data)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_fall_starts: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(state == ETRH_WAIT && in_fall && i_ext_source_en && !i_external_mode_select_key)
		|=> meas_start)
		else $error("falling edge did not start a measurement");
	chk_gate_source: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(state == ETRH_WAIT && !i_ext_source_en && !i_manual_trigger_key && !i_bus_trigger)
		|=> !meas_start)
		else $error("trigger taken while source not external");
	chk_key_one_rdg: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		meas_start |-> state == ETRH_MEAS && !$past(meas_start))
		else $error("more than one start per trigger");
	chk_store_first: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$rose(pulse) |-> $past(state) == ETRH_STORE)
		else $error("pulse without a stored reading");
	chk_after_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(state == ETRH_MEAS && !i_meas_done) |=> !pulse)
		else $error("pulse before device action finished");
	chk_pulse_line: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		pulse |-> !o_link_lines[$past(out_idx)])
		else $error("completion pulse missing on output line");
	chk_back_wait: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$fell(pulse) |-> state == ETRH_WAIT)
		else $error("no return to waiting after pulse");
	chk_mode_toggle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(state == ETRH_WAIT && i_external_mode_select_key) |=> ##1 !o_ext_mode && !o_manual_trigger_key_indicator)
		else $error("mode key did not leave external mode");
	chk_enter_lamp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(state == ETRH_IDLE && i_external_mode_select_key) |=> o_manual_trigger_key_indicator && o_wait_dashes)
		else $error("indicator not lit on external mode entry");
	cov_line_manual_trigger_key: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		state == ETRH_WAIT && in_fall ##1 meas_start);
	cov_full_cycle: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		$fell(pulse) ##[1:50] meas_start);
	cov_scan_wait: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		o_scan_wait_indicator);

endmodule

// file: verif/etrh_scanner.sv
// Scanner model at the far end of the trigger connector
`timescale 1ns/1ps
module etrh_scanner (
	// Clock
	input wire logic i_sys_clk,
	// Bench control
	input wire logic i_go,
	input wire logic [7:0] i_delay,
	input wire logic [3:0] i_chans,
	input wire logic [2:0] i_out_idx,
	input wire logic [2:0] i_in_idx,
	// Connector
	input wire logic [5:0] i_lines,
	output logic [5:0] o_lines
);
	logic prev = 1'b1; // Last level of the completion line
	int chan = 0; // Channels closed in this scan

	// ****************************************************************
	// Channel stepping
	// ****************************************************************
	// First channel closes on go without waiting, later ones on each completion fall
	initial begin
		o_lines = 6'h3F;
		forever begin
			@(posedge i_sys_clk);
			if (i_go) begin
				chan = 0;
			end
			if ((i_go || (prev && !i_lines[i_out_idx])) && chan < i_chans) begin
				chan++;
				// Relay settling time, slow or fast as the bench asks
				repeat (i_delay) @(negedge i_sys_clk);
				o_lines[i_in_idx] = 1'b0;
				repeat (3) @(negedge i_sys_clk);
				// Released lines return to the pull-up level
				o_lines = 6'h3F;
			end
			prev = i_lines[i_out_idx];
		end
	end
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the trigger handshake controller
`timescale 1ns/1ps
module tb_top;
	import etrh_pkg::*;
	localparam int PW = 4; // Short completion pulse keeps the run brief
	logic i_sys_clk = 0, i_rst = 1, mkey = 0, tkey = 0, scan = 0, btrig = 0, ext_en = 0;
	logic [1:0] osel = 0, isel = 0;
	logic [5:0] lout, loe, slines;
	logic mstart, mdone = 0, tind, dash, sind, emode, go = 0;
	logic [23:0] mdata = 0, rdata, note_q[$];
	logic [9:0] raddr = 0, wcnt;
	logic [31:0] rs = 32'h25;
	logic [7:0] dly = 1;
	int err_total = 0, check_count = 0, n_meas = 0, n_done = 0, s;
	// Open-drain style wire: undriven lines float to the pull-up level
	wire [5:0] blvl = (~loe | lout) & slines;
	wire [2:0] po = 3'(oidx(osel));
	wire [2:0] pi = 3'(oidx(isel) + 1);

	function automatic int oidx(input logic [1:0] v);
		return (v == 2'h3) ? 0 : 2 * v;
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic press(ref logic k);
		k = 1'b1;
		@(negedge i_sys_clk);
		k = 1'b0;
	endtask
	// Bounded wait for n completed handshakes; a hang ends the run
	task automatic wait_for(input int n);
		for (int k = 0; k < 3000 && n_done < n; k++) @(negedge i_sys_clk);
		if (n_done < n) begin
			err_total++;
			$display("ERROR %0t wait expired %0h %0h", $time, n_done, n);
			final_report();
		end
	endtask

	etrh_ctrl #(.PULSE_CYC(PW)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_external_mode_select_key(mkey), .i_manual_trigger_key(tkey), .i_scan_start(scan),
		.i_bus_trigger(btrig), .i_ext_source_en(ext_en), .i_out_line_sel(osel),
		.i_in_line_sel(isel), .i_link_lines(blvl), .o_link_lines(lout),
		.o_link_lines_oe(loe), .o_meas_start(mstart), .i_meas_done(mdone),
		.i_meas_data(mdata), .o_manual_trigger_key_indicator(tind), .o_wait_dashes(dash),
		.o_scan_wait_indicator(sind), .o_ext_mode(emode), .i_rd_addr(raddr),
		.o_rd_data(rdata), .o_wr_count(wcnt));
	etrh_scanner scanner (.i_sys_clk(i_sys_clk), .i_go(go), .i_delay(dly), .i_chans(4'h3),
		.i_out_idx(po), .i_in_idx(pi), .i_lines(blvl), .o_lines(slines));

	// ****************************************************************
	// Clock, measuring engine and completion watcher
	// ****************************************************************
	initial forever #20 i_sys_clk = ~i_sys_clk;
	// Engine answers each start after a random time and notes the reading
	initial forever begin
		@(negedge i_sys_clk);
		if (mstart === 1'b1) begin
			n_meas++;
			rs = xs(rs);
			repeat (rs[2:0] + 1) @(negedge i_sys_clk);
			mdata = rs[23:0];
			mdone = 1'b1;
			note_q.push_back(rs[23:0]);
			@(negedge i_sys_clk);
			mdone = 1'b0;
		end
	end
	// Each completion fall takes the oldest note: count, width, then stored value
	initial forever begin
		@(negedge i_sys_clk);
		if (!i_rst && blvl[po] === 1'b0) begin
			check(note_q.size(), 1);
			check(wcnt, n_done + 1);
			for (s = 0; s < PW + 8 && blvl[po] === 1'b0; s++) @(negedge i_sys_clk);
			check(s, PW);
			check(dash, 1'b1);
			raddr = 10'(n_done);
			repeat (2) @(negedge i_sys_clk);
			check(rdata, note_q.pop_front());
			n_done++;
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (10) @(negedge i_sys_clk);
		i_rst = 0;
		@(negedge i_sys_clk);
		check({loe, lout}, 12'h07F);
		press(tkey);
		repeat (5) @(negedge i_sys_clk);
		check(n_meas, 0);
		press(mkey);
		check({tind, dash, emode}, 3'h7);
		press(tkey);
		wait_for(1);
		press(btrig);
		wait_for(2);
		// Line pulses refused while the line source is off
		go = 1;
		@(negedge i_sys_clk);
		go = 0;
		repeat (60) @(negedge i_sys_clk);
		check(n_meas, 2);
		ext_en = 1;
		// Each line pairing runs a three-channel scan with a random settling time of 1 to 16 cycles
		for (int k = 0; k < 4; k++) begin
			osel = 2'(k);
			isel = 2'(k);
			rs = xs(rs);
			dly = 8'(rs[3:0] + 1);
			@(negedge i_sys_clk);
			check(loe, 6'h1 << oidx(osel));
			press(scan);
			check({sind, dash}, 2'h2);
			press(go);
			wait_for(5 + 3 * k);
		end
		press(mkey);
		check({tind, emode}, 2'h0);
		press(tkey);
		repeat (20) @(negedge i_sys_clk);
		check(n_meas, 14);
		final_report();
	end
endmodule
